// ---- rtl/network_cycle_resize_monitor.sv ----
/*
 Cycle resize monitor of one station on a cyclic time-shared network:
 slot timing, monitoring before start, resize requests with arbitration,
 and detection of break packets from stations stuck outside the cycle.
 Assumes a packet receiver and sender on the same core clock, so packet
 strobes need no synchroniser.
 A resize claim counts as simultaneous until it has gone round one cycle.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
// What this block does
// - Before start, packets still update flags, last frame, timing; no memory or mail.
// - Last frame register holds six bits, resets to 63.
// - Current slot time reads in control bits 0 to 6, before and after start.
// - With no peers heard, slot counter free-runs on its own prescaler.
// - Receive flags show operating stations outside the own area, from packets in any slot.
// - Pending register writes are ignored outside the RUN phase.
// - Nonzero pending values below the top of the owned range are rejected.
// - Run bit 9 of control shows whether the station is still running.
// - A resize from the station holding the network updates the last frame index everywhere.
// - The first resize request holds the network; later requests are ignored.
// - Simultaneous requests: the smallest station number wins.
// - An ignored request sets the overlap flag, status bit 8.
// - Writing one to the overlap flag clears it.
// - A pending station resizes in its next own slot after the winner releases with zero.
// - Only memory-sharing stations may request a resize.
// - On start, enter BREAK if owned range exceeds last frame, or if restarting after out-of-cycle stop.
// - In RUN, a break packet in public frames sets break flag, status bit 10.
// - Writing one clears the break flag; a further break packet sets it again.
`timescale 1ns/100ps
module network_cycle_resize_monitor
	import resize_monitor_pkg::*;
#(
	parameter int SlotCycles = SLOT_CYCLES,
	parameter int PublicFrames = PUBLIC_FRAMES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire reg_req_type regReq,
	output logic [15:0] regRdData,
	// Packet receiver and sender
	input wire pkt_type rxPkt,
	input wire logic outOfCycleStop,
	output pkt_type txPkt,
	// Gates toward shared memory and mail, and last frame change strobe
	output logic shmemUpdateEn,
	output logic mailAcceptEn,
	output logic lastFrameChanged
);

	localparam logic [15:0] SLOT_LAST = 16'(SlotCycles - 1);
	localparam logic [6:0] PUBLIC_COUNT = 7'(PublicFrames);

	typedef struct packed {
		phase_type phase;
		logic startBit;
		logic ocSeen;
		logic [5:0] stationNumber;
		logic [5:0] ownWidth;
		logic memMode;
		logic [15:0] presc;
		logic [6:0] slotTime;
		logic [5:0] lastFrameIndex;
		logic [5:0] pendingLastFrame;
		logic ownerValid;
		logic [5:0] owner;
		// Our own claim is still young enough to lose to a smaller number
		logic claimFresh;
		logic overlapFlag;
		logic overlapRaised;
		logic breakFlag;
		logic breakSent;
		logic [63:0] receiveFlags;
		logic [15:0] rdData;
		pkt_type tx;
		logic shmemEn;
		logic mailEn;
		logic fsChanged;
	} state_type;

	state_type state;
	state_type next_state;

	// Highest station address of the own area
	function automatic logic [6:0] ownTop(input logic [5:0] num, input logic [5:0] width);
		logic [6:0] sum;
		sum = {1'b0, num} + {1'b0, width};
		ownTop = (width == 6'h00) ? {1'b0, num} : 7'(sum - 7'h01);
	endfunction : ownTop

	// One bit per station address inside the own area
	function automatic logic [63:0] ownMask(input logic [5:0] num, input logic [5:0] width);
		logic [63:0] m;
		m = 64'h0000_0000_0000_0000;
		for (int i = 0; i < 64; i++) begin
			if (7'(i) >= {1'b0, num} && 7'(i) <= ownTop(num, width)) begin
				m[i] = 1'b1;
			end
		end
		ownMask = m;
	endfunction : ownMask

	function automatic pkt_type makePkt(input pkt_kind_type kind, input logic [5:0] src,
			input logic [6:0] slot, input logic [5:0] value);
		pkt_type p;
		p.valid = 1'b1;
		p.kind = kind;
		p.source = src;
		p.slot = slot;
		p.value = value;
		makePkt = p;
	endfunction : makePkt

	always_comb begin
		logic tick;
		logic inPublic;
		logic rxPublic;
		logic [6:0] cycleEnd;
		logic [6:0] top;
		logic [15:0] ctrlWord;
		logic [15:0] statusWord;
		logic [63:0] shownFlags;
		logic [5:0] oldFrame;
		tick = 1'b0;
		inPublic = 1'b0;
		rxPublic = 1'b0;
		cycleEnd = 7'h00;
		top = 7'h00;
		ctrlWord = 16'h0000;
		statusWord = 16'h0000;
		shownFlags = 64'h0000_0000_0000_0000;
		oldFrame = state.lastFrameIndex;
		next_state = state;
		next_state.tx.valid = 1'b0;
		next_state.fsChanged = 1'b0;
		top = ownTop(state.stationNumber, state.ownWidth);
		cycleEnd = 7'({1'b0, state.lastFrameIndex} + PUBLIC_COUNT);
		inPublic = state.slotTime > {1'b0, state.lastFrameIndex};
		// A received packet is timed by the slot it was sent in, not by our count
		rxPublic = rxPkt.slot > {1'b0, state.lastFrameIndex};

		// Read data stands one cycle after the read strobe
		ctrlWord[SLOT_TIME_LSB +: 7] = state.slotTime;
		ctrlWord[START_BIT] = state.startBit;
		ctrlWord[RUN_BIT] = (state.phase == PH_RUN);
		statusWord[OVERLAP_BIT] = state.overlapFlag;
		statusWord[BREAK_BIT] = state.breakFlag;
		shownFlags = state.receiveFlags & ~ownMask(state.stationNumber, state.ownWidth);
		next_state.rdData = 16'h0000;
		if (regReq.read) begin
			if (regReq.addr == ADDR_SYS_CONTROL) begin
				next_state.rdData = ctrlWord;
			end else if (regReq.addr == ADDR_SYS_STATUS) begin
				next_state.rdData = statusWord;
			end else if (regReq.addr == ADDR_LAST_FRAME) begin
				next_state.rdData = {10'h000, state.lastFrameIndex};
			end else if (regReq.addr == ADDR_PENDING_LAST_FRAME) begin
				next_state.rdData = {10'h000, state.pendingLastFrame};
			end else if (regReq.addr >= ADDR_RECEIVE_FLAG0 && regReq.addr <= ADDR_RECEIVE_FLAG3) begin
				next_state.rdData = shownFlags[16 * regReq.addr[1:0] +: 16];
			end else if (regReq.addr == ADDR_STATION_CONFIG) begin
				next_state.rdData[STATION_NUMBER_LSB +: 6] = state.stationNumber;
				next_state.rdData[OWN_WIDTH_LSB +: 6] = state.ownWidth;
				next_state.rdData[MEM_MODE_BIT] = state.memMode;
			end
		end

		// Software writes come first so that hardware events below win
		if (regReq.write) begin
			if (regReq.addr == ADDR_SYS_CONTROL) begin
				next_state.startBit = regReq.wrData[START_BIT];
			end else if (regReq.addr == ADDR_SYS_STATUS) begin
				if (regReq.wrData[OVERLAP_BIT]) begin
					next_state.overlapFlag = 1'b0;
				end
				if (regReq.wrData[BREAK_BIT]) begin
					next_state.breakFlag = 1'b0;
				end
			end else if (regReq.addr == ADDR_PENDING_LAST_FRAME) begin
				// Rejected writes leave the old value for the read-back check
				if (state.phase == PH_RUN) begin
					if (regReq.wrData[5:0] == 6'h00 || {1'b0, regReq.wrData[5:0]} >= top) begin
						next_state.pendingLastFrame = regReq.wrData[5:0];
						next_state.overlapRaised = 1'b0;
					end
				end
			end else if (regReq.addr == ADDR_STATION_CONFIG) begin
				// Identity is fixed while the station takes part in the cycle
				if (state.phase == PH_STOP) begin
					next_state.stationNumber = regReq.wrData[STATION_NUMBER_LSB +: 6];
					next_state.ownWidth = regReq.wrData[OWN_WIDTH_LSB +: 6];
					next_state.memMode = regReq.wrData[MEM_MODE_BIT];
				end
			end
		end

		// Phase control
		if (outOfCycleStop) begin
			next_state.phase = PH_STOP;
			next_state.ocSeen = 1'b1;
		end else if (!state.startBit) begin
			next_state.phase = PH_STOP;
		end else if (state.phase == PH_STOP) begin
			if (state.ocSeen || top > {1'b0, state.lastFrameIndex}) begin
				next_state.phase = PH_BREAK;
			end else begin
				next_state.phase = PH_RUN;
			end
			next_state.ocSeen = 1'b0;
			next_state.breakSent = 1'b0;
		end else if (state.phase == PH_BREAK && top <= {1'b0, state.lastFrameIndex}) begin
			// Admitted once the last frame index reaches the top of the own area
			next_state.phase = PH_RUN;
		end
		next_state.shmemEn = state.startBit && (state.phase == PH_RUN);
		next_state.mailEn = state.startBit && (state.phase == PH_RUN);

		// Slot timing; runs on its own until a peer packet aligns it
		if (state.presc == SLOT_LAST) begin
			next_state.presc = 16'h0000;
			tick = 1'b1;
		end else begin
			next_state.presc = 16'(state.presc + 16'h0001);
		end
		if (tick) begin
			if (state.slotTime >= cycleEnd) begin
				next_state.slotTime = 7'h00;
				next_state.receiveFlags = 64'h0000_0000_0000_0000;
				next_state.breakSent = 1'b0;
			end else begin
				next_state.slotTime = 7'(state.slotTime + 7'h01);
			end
		end

		// Own slot: claim, release, or announce the current index
		if (tick && state.phase == PH_RUN && state.slotTime == {1'b0, state.stationNumber}) begin
			// Once our slot comes round again, every station has heard our claim
			next_state.claimFresh = 1'b0;
			if (state.memMode && state.pendingLastFrame != 6'h00) begin
				if (!state.ownerValid || state.owner == state.stationNumber) begin
					next_state.claimFresh = !state.ownerValid;
					next_state.ownerValid = 1'b1;
					next_state.owner = state.stationNumber;
					next_state.lastFrameIndex = state.pendingLastFrame;
					next_state.tx = makePkt(PKT_RESIZE, state.stationNumber, state.slotTime,
						state.pendingLastFrame);
				end else begin
					if (!state.overlapRaised) begin
						next_state.overlapFlag = 1'b1;
						next_state.overlapRaised = 1'b1;
					end
					next_state.tx = makePkt(PKT_DATA, state.stationNumber, state.slotTime,
						state.lastFrameIndex);
				end
			end else if (state.ownerValid && state.owner == state.stationNumber) begin
				// Writing zero gives the network back to other requesters
				next_state.ownerValid = 1'b0;
				next_state.tx = makePkt(PKT_RESIZE, state.stationNumber, state.slotTime, 6'h00);
			end else begin
				next_state.tx = makePkt(PKT_DATA, state.stationNumber, state.slotTime,
					state.lastFrameIndex);
			end
		end

		// A station outside the cycle knocks once per cycle in the public frames
		if (tick && state.phase == PH_BREAK && inPublic && !state.breakSent) begin
			next_state.breakSent = 1'b1;
			next_state.tx = makePkt(PKT_BREAK, state.stationNumber, state.slotTime, 6'h00);
		end

		// Peer packets are heard in every phase, started or not
		if (rxPkt.valid) begin
			next_state.slotTime = rxPkt.slot;
			next_state.presc = 16'h0000;
			next_state.receiveFlags[rxPkt.source] = 1'b1;
			if (rxPkt.kind == PKT_DATA) begin
				// An owner keeps its own index against data packets sent before its claim
				if (!state.ownerValid || state.owner != state.stationNumber) begin
					next_state.lastFrameIndex = rxPkt.value;
				end
			end else if (rxPkt.kind == PKT_RESIZE) begin
				if (rxPkt.value == 6'h00) begin
					// Zero releases only when it comes from the current owner
					if (state.ownerValid && state.owner == rxPkt.source) begin
						next_state.ownerValid = 1'b0;
					end
				end else if (!state.ownerValid || state.owner == rxPkt.source) begin
					// Slot order makes the smaller number speak first in a cycle
					next_state.ownerValid = 1'b1;
					next_state.owner = rxPkt.source;
					next_state.lastFrameIndex = rxPkt.value;
				end else if (state.memMode && state.pendingLastFrame != 6'h00 && state.claimFresh
						&& state.owner == state.stationNumber
						&& rxPkt.source < state.stationNumber) begin
					// Simultaneous claim by a smaller number takes the network; once our
					// claim has gone round, any later claim is ignored instead
					next_state.claimFresh = 1'b0;
					next_state.owner = rxPkt.source;
					next_state.lastFrameIndex = rxPkt.value;
					if (!state.overlapRaised) begin
						next_state.overlapFlag = 1'b1;
						next_state.overlapRaised = 1'b1;
					end
				end
			end else if (rxPkt.kind == PKT_BREAK) begin
				if (state.phase == PH_RUN && rxPublic) begin
					next_state.breakFlag = 1'b1;
				end
			end
		end

		next_state.fsChanged = (next_state.lastFrameIndex != oldFrame);
	end

	// Reset leaves the station stopped with the full-size cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
			state.phase <= PH_STOP;
			state.ownWidth <= OWN_WIDTH_RESET;
			state.memMode <= 1'b1;
			state.lastFrameIndex <= LAST_FRAME_RESET;
			state.pendingLastFrame <= PENDING_RESET;
			state.tx.kind <= PKT_DATA;
		end else begin
			state <= next_state;
		end
	end

	// Every output is a field of the state register
	assign regRdData = state.rdData;
	assign txPkt = state.tx;
	assign shmemUpdateEn = state.shmemEn;
	assign mailAcceptEn = state.mailEn;
	assign lastFrameChanged = state.fsChanged;

endmodule : network_cycle_resize_monitor

// ---- rtl/resize_monitor_pkg.sv ----
/*
 Package for the cycle resize monitor: register map, field positions,
 reset values, timing counts and the packed types carried between the
 station's packet logic and this block.
 Assumes a 16-bit register port and a 10 MHz core clock.
*/
package resize_monitor_pkg;

	// Register indices on the 4-bit register port
	localparam logic [3:0] ADDR_SYS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SYS_STATUS = 4'h1;
	localparam logic [3:0] ADDR_LAST_FRAME = 4'h2;
	localparam logic [3:0] ADDR_PENDING_LAST_FRAME = 4'h3;
	localparam logic [3:0] ADDR_RECEIVE_FLAG0 = 4'h4;
	localparam logic [3:0] ADDR_RECEIVE_FLAG3 = 4'h7;
	localparam logic [3:0] ADDR_STATION_CONFIG = 4'h8;

	// System control register fields
	localparam int SLOT_TIME_LSB = 0;
	localparam int START_BIT = 8;
	localparam int RUN_BIT = 9;

	// System status register fields
	localparam int OVERLAP_BIT = 8;
	localparam int BREAK_BIT = 10;

	// Station configuration register fields
	localparam int STATION_NUMBER_LSB = 0;
	localparam int OWN_WIDTH_LSB = 8;
	localparam int MEM_MODE_BIT = 15;

	// Reset values
	localparam logic [5:0] LAST_FRAME_RESET = 6'h3F;
	localparam logic [5:0] PENDING_RESET = 6'h00;
	localparam logic [5:0] OWN_WIDTH_RESET = 6'h01;

	// Timing: length of one slot and number of public frames of the cyclic schedule
	localparam int CORE_CLK_HZ = 10_000_000;
	localparam int SLOT_TIME_NS = 1600;
	localparam int SLOT_CYCLES = (SLOT_TIME_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PUBLIC_FRAMES = 2;

	typedef enum logic [1:0] {
		PKT_DATA,
		PKT_RESIZE,
		PKT_BREAK
	} pkt_kind_type;

	// One packet as seen on the cyclic bus; value carries the last frame
	// index for data packets and the requested index for resize packets
	typedef struct packed {
		logic valid;
		pkt_kind_type kind;
		logic [5:0] source;
		logic [6:0] slot;
		logic [5:0] value;
	} pkt_type;

	typedef enum logic [1:0] {
		PH_STOP,
		PH_RUN,
		PH_BREAK
	} phase_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wrData;
		logic write;
		logic read;
	} reg_req_type;

endpackage : resize_monitor_pkg

// ---- testbench/peer_station_model.sv ----
/*
 Peer station model: puts one packet per bench request on the receive side.
 Assumes the bench raises requests on the core clock.
*/
`timescale 1ns/100ps
module peer_station_model
	import resize_monitor_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Request from the bench
	input wire logic sendReq,
	input wire pkt_type sendPkt,
	// Packet toward the station
	output pkt_type rxPkt
);
	pkt_type idlePkt;

	// Idle fields keep toggling so nothing can lean on a stale packet
	always_comb begin
		idlePkt = ~rxPkt;
		idlePkt.valid = 1'b0;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxPkt <= '0;
		end else if (sendReq) begin
			rxPkt <= sendPkt;
		end else begin
			rxPkt <= idlePkt;
		end
	end
endmodule : peer_station_model

// ---- testbench/resize_monitor_checker.sv ----
/*
 Port checker for the cycle resize monitor.
 Assumes it is bound to the monitor top and sees its ports only.
*/
`timescale 1ns/100ps
module resize_monitor_checker
	import resize_monitor_pkg::*;
#(
	parameter int PublicFrames = PUBLIC_FRAMES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire reg_req_type regReq,
	input wire logic [15:0] regRdData,
	// Packet side and gates
	input wire pkt_type txPkt,
	input wire logic shmemUpdateEn,
	input wire logic mailAcceptEn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_read_idle_zero: assert property (!$past(regReq.read) |-> regRdData == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_frame_six_bits: assert property ($past(regReq.read) && ($past(regReq.addr) ==
		ADDR_LAST_FRAME || $past(regReq.addr) == ADDR_PENDING_LAST_FRAME)
		|-> regRdData[15:6] == 10'h000)
		else $error("frame register wider than six bits");
	a_slot_range: assert property ($past(regReq.read) && $past(regReq.addr) ==
		ADDR_SYS_CONTROL |-> int'(regRdData[6:0]) <= 63 + PublicFrames && !regRdData[7])
		else $error("slot time out of range");
	a_no_share_stopped: assert property ($past(regReq.read) && $past(regReq.addr) ==
		ADDR_SYS_CONTROL && !regRdData[START_BIT] |-> !shmemUpdateEn && !mailAcceptEn)
		else $error("memory or mail open before start");
	a_run_gates: assert property ($past(regReq.read) && $past(regReq.addr) ==
		ADDR_SYS_CONTROL && !regRdData[RUN_BIT] |-> !shmemUpdateEn)
		else $error("memory open outside run phase");
	a_gates_paired: assert property (shmemUpdateEn == mailAcceptEn)
		else $error("memory and mail gates differ");
	a_status_bits: assert property ($past(regReq.read) && $past(regReq.addr) ==
		ADDR_SYS_STATUS |-> (regRdData & 16'hFAFF) == 16'h0000)
		else $error("status shows undefined bits");
	a_unmapped_zero: assert property ($past(regReq.read) && $past(regReq.addr) >
		ADDR_STATION_CONFIG |-> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_tx_single: assert property (txPkt.valid |=> !txPkt.valid)
		else $error("packet strobe longer than one cycle");
endmodule : resize_monitor_checker

bind network_cycle_resize_monitor resize_monitor_checker #(.PublicFrames(PublicFrames))
	resize_monitor_checker_inst (.core_clk, .rst, .regReq, .regRdData, .txPkt,
	.shmemUpdateEn, .mailAcceptEn);

// ---- testbench/tb_top.sv ----
/*
 Testbench for the cycle resize monitor with one peer station model.
 Assumes the monitor and the peer share the core clock.
*/
`timescale 1ns/100ps
module tb_top;
	import resize_monitor_pkg::*;
	localparam int Slots = 4;
	localparam int Pub = 2;
	// One full-size cycle: long enough for our own slot to come round
	localparam int CycleClk = (64 + Pub) * Slots;
	logic core_clk;
	logic rst;
	reg_req_type regReq;
	logic [15:0] regRdData;
	pkt_type rxPkt;
	pkt_type txPkt;
	pkt_type peerPkt;
	logic peerSend;
	logic outOfCycleStop;
	logic shmemUpdateEn;
	logic mailAcceptEn;
	logic lastFrameChanged;
	int error_cnt;
	int n_checks;
	int seed;
	logic [15:0] rd;
	logic [15:0] s0;
	logic [5:0] v;
	int fsChanges;
	logic [5:0] lastTxResize;

	network_cycle_resize_monitor #(.SlotCycles(Slots), .PublicFrames(Pub))
		network_cycle_resize_monitor_inst (.core_clk, .rst, .regReq, .regRdData, .rxPkt,
		.outOfCycleStop, .txPkt, .shmemUpdateEn, .mailAcceptEn, .lastFrameChanged);
	peer_station_model peer_station_model_inst (.core_clk, .rst, .sendReq(peerSend),
		.sendPkt(peerPkt), .rxPkt);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Counts index changes and remembers the last resize the station sent
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fsChanges <= 0;
			lastTxResize <= 6'h00;
		end else begin
			if (lastFrameChanged)
				fsChanges <= fsChanges + 1;
			if (txPkt.valid && txPkt.kind == PKT_RESIZE)
				lastTxResize <= txPkt.value;
		end
	end

	// Owned top is station 2 plus width 5 less one
	function automatic logic [15:0] exp_pending(input logic [5:0] val, input logic [15:0] old);
		return (val == 6'h00 || val >= 6'h06) ? {10'h000, val} : old;
	endfunction : exp_pending

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
		@(posedge core_clk);
		regReq <= '{addr, data, 1'b1, 1'b0};
		@(posedge core_clk);
		regReq.write <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] addr, output logic [15:0] data);
		@(posedge core_clk);
		regReq <= '{addr, 16'h0000, 1'b0, 1'b1};
		@(posedge core_clk);
		regReq.read <= 1'b0;
		#1;
		data = regRdData;
	endtask : reg_read

	task automatic peer(input pkt_kind_type k, input logic [5:0] src, input logic [6:0] slot,
		input logic [5:0] val);
		@(posedge core_clk);
		peerPkt <= '{1'b1, k, src, slot, val};
		peerSend <= 1'b1;
		@(posedge core_clk);
		peerSend <= 1'b0;
	endtask : peer

	// Bounded poll; a register that never settles ends the run
	task automatic poll(input logic [3:0] addr, input logic [15:0] mask, input logic [15:0] exp);
		int i;
		for (i = 0; i < 3000; i++) begin
			reg_read(addr, rd);
			if ((rd & mask) === exp)
				break;
		end
		check(rd & mask, exp);
		if (i == 3000)
			finish_test();
	endtask : poll

	initial begin
		seed = 82;
		error_cnt = 0;
		n_checks = 0;
		rst = 1'b1;
		regReq = '0;
		peerPkt = '0;
		peerSend = 1'b0;
		outOfCycleStop = 1'b0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		reg_read(ADDR_LAST_FRAME, rd);
		check(rd, 16'h003F);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h0010);
		reg_read(ADDR_PENDING_LAST_FRAME, rd);
		check(rd, 16'h0000);
		reg_write(ADDR_STATION_CONFIG, 16'h8502);
		$display("test reset done");
		reg_read(ADDR_SYS_CONTROL, s0);
		repeat (4 * Slots - 2) @(posedge core_clk);
		reg_read(ADDR_SYS_CONTROL, rd);
		check({9'h000, rd[6:0]}, 16'((int'(s0[6:0]) + 4) % (64 + Pub)));
		v = 6'd8 + 6'($random(seed) & 7);
		peer(PKT_DATA, v, {1'b0, v}, 6'h3F);
		reg_read(ADDR_SYS_CONTROL, rd);
		check({9'h000, rd[6:0]}, {10'h000, v});
		reg_read(ADDR_RECEIVE_FLAG0, rd);
		check(rd, 16'h0001 << v);
		check({15'h0000, shmemUpdateEn}, 16'h0000);
		$display("test monitor done");
		reg_write(ADDR_SYS_CONTROL, 16'h0100);
		repeat (3) @(posedge core_clk);
		check({15'h0000, shmemUpdateEn}, 16'h0001);
		reg_read(ADDR_SYS_CONTROL, rd);
		check({15'h0000, rd[RUN_BIT]}, 16'h0001);
		for (int i = 0; i < 7; i++) begin
			v = (i == 6) ? 6'h06 : (i == 5) ? 6'h05 : 6'd1 + 6'($random(seed) & 3);
			reg_write(ADDR_PENDING_LAST_FRAME, {10'h000, v});
			reg_read(ADDR_PENDING_LAST_FRAME, rd);
			check(rd, exp_pending(v, 16'h0000));
		end
		poll(ADDR_LAST_FRAME, 16'h003F, 16'h0006);
		repeat (CycleClk) @(posedge core_clk);
		peer(PKT_RESIZE, 6'd1, 7'd1, 6'd20);
		repeat (Slots) @(posedge core_clk);
		reg_read(ADDR_LAST_FRAME, rd);
		check(rd, 16'h0006);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h0000);
		reg_read(ADDR_PENDING_LAST_FRAME, rd);
		check(rd, 16'h0000);
		$display("test resize done");
		repeat (CycleClk) @(posedge core_clk);
		peer(PKT_RESIZE, 6'd1, 7'd1, 6'd30);
		poll(ADDR_LAST_FRAME, 16'h003F, 16'h001E);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h000A);
		poll(ADDR_SYS_STATUS, 16'h0100, 16'h0100);
		reg_read(ADDR_LAST_FRAME, rd);
		check(rd, 16'h001E);
		reg_write(ADDR_SYS_STATUS, 16'h0100);
		reg_read(ADDR_SYS_STATUS, rd);
		check(rd & 16'h0100, 16'h0000);
		peer(PKT_RESIZE, 6'd1, 7'd1, 6'd0);
		poll(ADDR_LAST_FRAME, 16'h003F, 16'h000A);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h0000);
		$display("test overlap done");
		peer(PKT_BREAK, 6'd40, 7'd11, 6'd0);
		poll(ADDR_SYS_STATUS, 16'h0400, 16'h0400);
		reg_write(ADDR_SYS_STATUS, 16'h0400);
		reg_read(ADDR_SYS_STATUS, rd);
		check(rd & 16'h0400, 16'h0000);
		peer(PKT_BREAK, 6'd40, 7'd12, 6'd0);
		poll(ADDR_SYS_STATUS, 16'h0400, 16'h0400);
		$display("test break done");
		repeat (CycleClk) @(posedge core_clk);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h003F);
		poll(ADDR_LAST_FRAME, 16'h003F, 16'h003F);
		peer(PKT_RESIZE, 6'd1, 7'd1, 6'd20);
		poll(ADDR_LAST_FRAME, 16'h003F, 16'h0014);
		reg_read(ADDR_SYS_STATUS, rd);
		check(rd & 16'h0100, 16'h0100);
		reg_write(ADDR_PENDING_LAST_FRAME, 16'h0000);
		check({10'h000, lastTxResize}, 16'h003F);
		check(16'(fsChanges), 16'h0005);
		$display("test expand done");
		@(posedge core_clk);
		outOfCycleStop <= 1'b1;
		@(posedge core_clk);
		outOfCycleStop <= 1'b0;
		reg_read(ADDR_SYS_CONTROL, rd);
		check({15'h0000, rd[RUN_BIT]}, 16'h0000);
		poll(ADDR_SYS_CONTROL, 16'h0200, 16'h0200);
		$display("test restart done");
		finish_test();
	end
endmodule : tb_top
